/* File: hw/ibx_params.svh */
// constants for the expansion bus control and x-bus decode block
`ifndef IBX_PARAMS_SVH
`define IBX_PARAMS_SVH

`define IBX_RTC_INDEX_PORT 16'h0070
`define IBX_RTC_DATA_PORT 16'h0071
`define IBX_KBD_PORT_A 16'h0060
`define IBX_KBD_PORT_B 16'h0064
`define IBX_MEG_LIMIT 24'h100000
`define IBX_ROM_BASE 24'h0E0000
`define IBX_HOST_HOLD_CLOCKS 2'h2
`define IBX_CMD_WAIT_CLOCKS 2'h3
`define IBX_IDLE_DACK 3'h7
`define IBX_NMI_CHK_BIT 3

`endif

/* File: hw/ibx_pkg.sv */
// shared types for the expansion bus control and x-bus decode block
`default_nettype none
package ibx_pkg;

  // kind of cycle the bus controller is running
  typedef enum logic [2:0]
  {
    IBX_IDLE = 3'b000,
    IBX_MEM = 3'b001,
    IBX_IO = 3'b010,
    IBX_DMA = 3'b011,
    IBX_REFRESH = 3'b100,
    IBX_MASTER = 3'b101
  } ibx_cycle_t;

  // one request from the host side
  typedef struct packed
  {
    ibx_cycle_t kind;
    logic write;
    logic [23:0] addr;
    logic high_byte;
  } ibx_req_t;

  // command strobes driven on the expansion bus, all active low
  typedef struct packed
  {
    logic memr_n;
    logic memw_n;
    logic smemr_n;
    logic smemw_n;
    logic ior_n;
    logic iow_n;
    logic bhe_n;
    logic refresh_n;
  } ibx_cmd_t;

endpackage
`default_nettype wire

/* File: hw/ibx_bus_control.sv */
// expansion bus command, direction, request mux and x-bus select logic
// Function
// - ale high in refresh, dma, master; low after reset
// - high byte enable driven, input under add-on master
// - command lines become inputs under add-on master
// - memory read asserted during every refresh
// - system strobes only below one megabyte, smemr also on every refresh
// - 16-bit memory select input, ignored io/refresh
// - never drive 16-bit io select
// - refresh line driven on refresh, master input
// - hold host bus two clocks for refresh
// - address enable whenever dma owns bus
// - zero wait state shortens current cycle
// - channel check plus enable raises nmi
// - shared pins carry selects or ide data
// - rom/rtc select on rom memory, rtc io
// - keyboard select on keyboard io decode
// - rtc write select on io write 71h
// - rtc data strobe on io read 71h
// - rtc address strobe on io write 70h
// - sample muxed requests by clock phase strobes
// - encoded dma acknowledge while valid, idle code otherwise
// - invert rtc interrupt before controller
// - terminal count on final dma transfer
// - channel ready out for master hitting internal registers, in otherwise
`timescale 1ns/10ps
`default_nettype none
`include "ibx_params.svh"

module ibx_bus_control
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic expansion_bus_clock,
  input wire logic expansion_bus_clock_double,
  input wire ibx_pkg::ibx_req_t req,
  input wire logic req_valid,
  output logic req_done,
  output logic host_bus_hold,
  input wire logic master_owns_n,
  input wire logic master_memr_n,
  input wire logic master_refresh_n,
  input wire logic mem_cs16_n,
  output logic mem_cs16_seen,
  output logic io_cs16_oe,
  input wire logic zero_wait_n,
  input wire logic chan_check_n,
  input wire logic [7:0] sys_ctrl_port,
  output logic nmi,
  output logic ale,
  output logic aen,
  output ibx_pkg::ibx_cmd_t cmd_out,
  output logic cmd_oe,
  input wire logic chrdy_in,
  output logic chrdy_out,
  output logic chrdy_oe,
  input wire logic master_hits_internal,
  input wire logic internal_ready,
  output logic xcvr_output_enable_n,
  output logic rom_rtc_select_n,
  output logic keyboard_select_n,
  output logic rtc_write_select_n,
  output logic rtc_data_strobe_n,
  output logic rtc_addr_strobe_n,
  input wire logic [3:0] ide_data_hi,
  output logic [3:0] shared_pins,
  input wire logic [3:0] muxed_irq_in,
  input wire logic [1:0] muxed_dma_req_in,
  output logic [15:0] irq_lines,
  output logic [7:0] dma_req_lines,
  input wire logic rtc_irq_low,
  output logic rtc_irq_to_ctrl,
  input wire logic [2:0] dma_ack_chan,
  input wire logic dma_ack_valid,
  output logic [2:0] encoded_dma_ack_out,
  input wire logic dma_last_transfer,
  output logic terminal_count
);

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    IBX_ST_IDLE = 2'b00,
    IBX_ST_HOLD = 2'b01,
    IBX_ST_CMD = 2'b10,
    IBX_ST_END = 2'b11
  } ibx_state_t;

  ibx_state_t state; // sequencer state
  ibx_state_t next_state; // next sequencer state
  ibx_pkg::ibx_req_t cur; // latched request
  logic [1:0] hold_cnt; // host bus hold counter
  logic [1:0] wait_cnt; // command wait counter

  wire master_active = ~master_owns_n;
  wire is_refresh = cur.kind == ibx_pkg::IBX_REFRESH;
  wire is_dma = cur.kind == ibx_pkg::IBX_DMA;
  wire is_io = cur.kind == ibx_pkg::IBX_IO;
  wire is_mem = cur.kind == ibx_pkg::IBX_MEM;
  wire in_cmd = state == IBX_ST_CMD;
  // a master may start refresh itself through the refresh line
  wire master_ref_req = master_active & ~master_refresh_n;
  // zero wait ends the command at once, else ready with wait count
  wire cmd_finish = in_cmd & (~zero_wait_n | (chrdy_in & wait_cnt == `IBX_CMD_WAIT_CLOCKS));
  wire start = state == IBX_ST_IDLE & req_valid & ~master_active;

  // next state decode
  always_comb
  begin
    next_state = state;
    unique case (state)
      IBX_ST_IDLE:
        if (start)
          next_state = req.kind == ibx_pkg::IBX_REFRESH ? IBX_ST_HOLD : IBX_ST_CMD;
      IBX_ST_HOLD:
        // refresh address goes out on the host bus for two clocks
        if (hold_cnt == `IBX_HOST_HOLD_CLOCKS - 2'h1)
          next_state = IBX_ST_CMD;
      IBX_ST_CMD:
        if (cmd_finish)
          next_state = IBX_ST_END;
      IBX_ST_END:
        next_state = IBX_ST_IDLE;
    endcase
  end

  // state, request latch and counters
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= IBX_ST_IDLE;
      cur <= '0;
      hold_cnt <= 2'h0;
      wait_cnt <= 2'h0;
    end
    else
    begin
      state <= next_state;
      if (start)
        cur <= req;
      hold_cnt <= state == IBX_ST_HOLD ? hold_cnt + 2'h1 : 2'h0;
      wait_cnt <= in_cmd && wait_cnt != `IBX_CMD_WAIT_CLOCKS ? wait_cnt + 2'h1 : (in_cmd ? wait_cnt : 2'h0);
    end
  end

  assign req_done = state == IBX_ST_END;
  assign host_bus_hold = state == IBX_ST_HOLD;

  // ------------------------------------------------------------
  // command strobes and direction
  // ------------------------------------------------------------
  wire below_meg = cur.addr < `IBX_MEG_LIMIT;
  wire rd_cmd = in_cmd & ~cur.write;
  wire wr_cmd = in_cmd & cur.write;
  wire memr_on = (rd_cmd & (is_mem | is_dma)) | (in_cmd & is_refresh);
  wire memw_on = wr_cmd & (is_mem | is_dma);
  // dma reads memory and writes io, or the reverse
  wire ior_on = (rd_cmd & is_io) | (wr_cmd & is_dma);
  wire iow_on = (wr_cmd & is_io) | (rd_cmd & is_dma);

  // registered strobes, outputs
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cmd_out <= '1;
      ale <= 1'b0;
      aen <= 1'b0;
    end
    else
    begin
      cmd_out.memr_n <= ~memr_on;
      cmd_out.memw_n <= ~memw_on;
      cmd_out.smemr_n <= ~(memr_on & (below_meg | is_refresh));
      cmd_out.smemw_n <= ~(memw_on & below_meg);
      cmd_out.ior_n <= ~ior_on;
      cmd_out.iow_n <= ~iow_on;
      cmd_out.bhe_n <= ~(in_cmd & cur.high_byte);
      cmd_out.refresh_n <= ~(in_cmd & is_refresh);
      ale <= master_active | (state != IBX_ST_IDLE & (is_refresh | is_dma));
      aen <= state != IBX_ST_IDLE & is_dma;
    end
  end

  // command, high byte and refresh lines turn round under a master
  assign cmd_oe = ~master_active;
  assign io_cs16_oe = 1'b0;
  // 16-bit memory select only counts on memory and dma cycles
  assign mem_cs16_seen = ~mem_cs16_n & in_cmd & ~is_io & ~is_refresh;
  // master cycles to internal registers run 8-bit, ready from us
  assign chrdy_oe = master_active & master_hits_internal;
  assign chrdy_out = internal_ready;

  // ------------------------------------------------------------
  // x-bus decode on shared pins
  // ------------------------------------------------------------
  // io decode terms; a master's own memory read is not decoded here
  wire io_rd = rd_cmd & is_io;
  wire io_wr = wr_cmd & is_io;
  wire [15:0] io_addr = cur.addr[15:0];
  wire rtc_hit = io_addr == `IBX_RTC_INDEX_PORT | io_addr == `IBX_RTC_DATA_PORT;
  wire rom_hit = is_mem & in_cmd & cur.addr >= `IBX_ROM_BASE & below_meg;
  wire kbd_hit = in_cmd & is_io & (io_addr == `IBX_KBD_PORT_A | io_addr == `IBX_KBD_PORT_B);
  wire next_romrtc = rom_hit | (in_cmd & is_io & rtc_hit);
  wire next_rtc_write_select_n = io_wr & io_addr == `IBX_RTC_DATA_PORT;
  wire next_rtc_data_strobe_n = io_rd & io_addr == `IBX_RTC_DATA_PORT;
  wire next_rtc_addr_strobe_n = io_wr & io_addr == `IBX_RTC_INDEX_PORT;
  wire unused_master = master_memr_n;

  // select flops, active low
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rom_rtc_select_n <= 1'b1;
      keyboard_select_n <= 1'b1;
      rtc_write_select_n <= 1'b1;
      rtc_data_strobe_n <= 1'b1;
      rtc_addr_strobe_n <= 1'b1;
      xcvr_output_enable_n <= 1'b1;
    end
    else
    begin
      rom_rtc_select_n <= ~next_romrtc;
      keyboard_select_n <= ~kbd_hit;
      rtc_write_select_n <= ~next_rtc_write_select_n;
      rtc_data_strobe_n <= ~next_rtc_data_strobe_n;
      rtc_addr_strobe_n <= ~next_rtc_addr_strobe_n;
      // transceiver opens for any expansion bus activity
      xcvr_output_enable_n <= ~(start | state != IBX_ST_IDLE | master_active | master_ref_req);
    end
  end

  // shared pins: selects while transceiver on, ide high data else
  assign shared_pins = ~xcvr_output_enable_n
    ? {rom_rtc_select_n, keyboard_select_n, rtc_write_select_n, rtc_data_strobe_n}
    : ide_data_hi;

  // ------------------------------------------------------------
  // multiplexed requests and encoded acknowledge
  // ------------------------------------------------------------
  // phase 0..3 from the two clock levels picks the slice
  wire [1:0] phase = {expansion_bus_clock, expansion_bus_clock_double};

  // demux the time-shared inputs into the phase slice
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_lines <= 16'h0000;
      dma_req_lines <= 8'h00;
    end
    else
    begin
      irq_lines[{phase, 2'b00} +: 4] <= muxed_irq_in;
      dma_req_lines[{phase, 1'b0} +: 2] <= muxed_dma_req_in;
    end
  end

  // rtc interrupt pin is active low, controller wants high
  assign rtc_irq_to_ctrl = ~irq_lines[8];

  // acknowledge code registered each clock while valid, idle code otherwise
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      encoded_dma_ack_out <= `IBX_IDLE_DACK;
      terminal_count <= 1'b0;
      nmi <= 1'b0;
    end
    else
    begin
      encoded_dma_ack_out <= dma_ack_valid ? dma_ack_chan : `IBX_IDLE_DACK;
      terminal_count <= dma_last_transfer & in_cmd & is_dma;
      nmi <= ~chan_check_n & sys_ctrl_port[`IBX_NMI_CHK_BIT];
    end
  end

endmodule
`default_nettype wire

/* File: tb/ibx_bus_control_properties.sv */
// assertions watching the expansion bus control ports
`timescale 1ns/10ps
`default_nettype none
module ibx_bus_control_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic master_owns_n,
  input wire logic chan_check_n,
  input wire logic [7:0] sys_ctrl_port,
  input wire logic nmi,
  input wire logic ale,
  input wire logic cmd_oe,
  input wire ibx_pkg::ibx_cmd_t cmd_out,
  input wire logic io_cs16_oe,
  input wire logic host_bus_hold,
  input wire logic xcvr_output_enable_n,
  input wire logic rom_rtc_select_n,
  input wire logic keyboard_select_n,
  input wire logic rtc_write_select_n,
  input wire logic rtc_data_strobe_n,
  input wire logic [3:0] ide_data_hi,
  input wire logic [3:0] shared_pins,
  input wire logic [15:0] irq_lines,
  input wire logic rtc_irq_to_ctrl,
  input wire logic [2:0] encoded_dma_ack_out
);
  // ------------------------------------------------
  // one clock domain, so one default clock and reset
  // ------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_cs16_never_driven: assert property (!io_cs16_oe)
    else $error("io cs16 driven");
  a_cmd_dir_master: assert property (cmd_oe == master_owns_n)
    else $error("command direction wrong");
  a_shared_pin_mux: assert property (shared_pins == (xcvr_output_enable_n ? ide_data_hi :
    {rom_rtc_select_n, keyboard_select_n, rtc_write_select_n, rtc_data_strobe_n}))
    else $error("shared pins wrong");
  a_rtc_irq_invert: assert property (rtc_irq_to_ctrl != irq_lines[8])
    else $error("rtc irq not inverted");
  // past values from reset time would be stale, so skip that edge
  a_nmi_from_check: assert property (!$past(sys_rst) |->
    nmi == $past(!chan_check_n && sys_ctrl_port[3])) else $error("nmi wrong");
  a_reset_idle_out: assert property ($fell(sys_rst) |->
    !ale && !nmi && encoded_dma_ack_out == 3'h7) else $error("reset outputs wrong");
  a_refresh_memr: assert property (master_owns_n && !cmd_out.refresh_n |->
    !cmd_out.memr_n) else $error("no memr in refresh");
  a_hold_two_clk: assert property ($rose(host_bus_hold) |=>
    host_bus_hold ##1 !host_bus_hold) else $error("host hold not two clocks");
endmodule
bind ibx_bus_control ibx_bus_control_properties ibx_bus_control_properties_i (.*);
`default_nettype wire

/* File: tb/ibx_card_model.sv */
// far-side card model: wait-state answers and multiplexed request lines
`timescale 1ns/10ps
`default_nettype none
module ibx_card_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire ibx_pkg::ibx_cmd_t cmd_out,
  input wire logic expansion_bus_clock,
  input wire logic expansion_bus_clock_double,
  input wire logic [15:0] irq_vec,
  input wire logic [7:0] drq_vec,
  output logic zero_wait_n,
  output logic chrdy_in,
  output logic mem_cs16_n,
  output logic [3:0] muxed_irq_in,
  output logic [1:0] muxed_dma_req_in
);
  // ------------------------------------------------
  // card answers
  // ------------------------------------------------
  wire logic [1:0] phase = {expansion_bus_clock, expansion_bus_clock_double}; // slice pick
  wire logic act = ~&{cmd_out.memr_n, cmd_out.memw_n, cmd_out.ior_n, cmd_out.iow_n};
  logic [2:0] cnt = 3'h0; // cycles of the current command
  // count command cycles so a slow card can stretch them
  always_ff @(posedge clk_sys)
    cnt <= act ? cnt + 3'h1 : 3'h0;
  assign zero_wait_n = ~(act & ~slow);
  // pulled up when idle; a slow card holds it low two cycles
  assign chrdy_in = ~(act & slow & (cnt < 3'h2));
  assign mem_cs16_n = 1'b0;
  assign muxed_irq_in = irq_vec[phase * 4 +: 4];
  assign muxed_dma_req_in = drq_vec[phase * 2 +: 2];
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the expansion bus control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error at %0t got %h exp %h", $time, g, e); end end
module tb_top;
  // ------------------------------------------------
  // signals, instances, clock
  // ------------------------------------------------
  logic clk_sys = 0, sys_rst = 1, expansion_bus_clock = 0, expansion_bus_clock_double = 0;
  logic req_valid = 0, master_owns_n = 1, master_memr_n = 1, master_refresh_n = 1, slow = 0;
  logic chan_check_n = 1, master_hits_internal = 0, internal_ready = 0, rtc_irq_low = 1;
  logic dma_ack_valid = 0, dma_last_transfer = 0, mem_cs16_n, zero_wait_n, chrdy_in;
  logic req_done, host_bus_hold, mem_cs16_seen, io_cs16_oe, nmi, ale, aen, cmd_oe, chrdy_out;
  logic chrdy_oe, xcvr_output_enable_n, rom_rtc_select_n, keyboard_select_n, rtc_write_select_n;
  logic rtc_data_strobe_n, rtc_addr_strobe_n, rtc_irq_to_ctrl, terminal_count;
  logic [1:0] muxed_dma_req_in;
  logic [2:0] dma_ack_chan = 3'h5, encoded_dma_ack_out;
  logic [3:0] ide_data_hi = 4'h9, muxed_irq_in, shared_pins;
  logic [7:0] sys_ctrl_port = 8'h08, dma_req_lines, drq_vec = 8'h5A;
  logic [15:0] irq_lines, irq_vec = 16'hA5C3;
  ibx_pkg::ibx_req_t req = '0;
  ibx_pkg::ibx_cmd_t cmd_out;
  int bad_count = 0, n_checks = 0, cyc = 0;
  ibx_bus_control ibx_bus_control_i (.*);
  ibx_card_model ibx_card_model_i (.*);
  always #12.5 clk_sys = ~clk_sys;
  // bus clock phase walks 0..3; cycle ceiling cuts a hang short
  always @(negedge clk_sys)
  begin
    {expansion_bus_clock, expansion_bus_clock_double} <= 2'(cyc + 1);
    internal_ready <= ~internal_ready;
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one host cycle; gathers what the block shows over a fixed window
  task automatic scen(ibx_pkg::ibx_cycle_t k, logic w, logic [23:0] a, logic hb, logic sl,
    logic [4:0] es, logic [7:0] ec);
    logic [4:0] s = '0;
    logic [7:0] c = '0;
    logic [3:0] f = '0;
    logic [3:0] p = '0;
    int d = 0;
    int h = 0;
    @(negedge clk_sys);
    req <= '{k, w, a, hb};
    req_valid <= 1;
    slow <= sl;
    dma_last_transfer <= (k == ibx_pkg::IBX_DMA);
    repeat (14)
    begin
      @(negedge clk_sys);
      req_valid <= 0;
      s |= ~{rom_rtc_select_n, keyboard_select_n, rtc_write_select_n, rtc_data_strobe_n,
        rtc_addr_strobe_n};
      c |= ~cmd_out;
      d += req_done;
      h += host_bus_hold;
      f |= {ale, aen, mem_cs16_seen, terminal_count};
      if (!xcvr_output_enable_n)
        p |= ~shared_pins;
    end
    `CHK(p, es[4:1])
    `CHK(shared_pins, master_owns_n ? 4'h9 : 4'hF)
    `CHK(chrdy_oe, !master_owns_n)
    dma_last_transfer <= 0;
    `CHK(s, es)
    if (ec != 8'hFF) `CHK(c, ec)
    `CHK(d, master_owns_n ? 1 : 0)
    `CHK(h, k == ibx_pkg::IBX_REFRESH ? 2 : 0)
    `CHK(f[2:0], {k == ibx_pkg::IBX_DMA, k inside {ibx_pkg::IBX_MEM, ibx_pkg::IBX_DMA},
      k == ibx_pkg::IBX_DMA})
    if (k inside {ibx_pkg::IBX_DMA, ibx_pkg::IBX_REFRESH} || !master_owns_n) `CHK(f[3], 1'b1)
    $display("test done kind %0d addr %h", k, a);
  endtask
  // add-on master owns the bus: host request refused
  task automatic tst_master();
    master_owns_n <= 0;
    master_refresh_n <= 0;
    master_hits_internal <= 1;
    scen(ibx_pkg::IBX_IO, 0, 24'h71, 0, 0, 5'h00, 8'h00);
    master_owns_n <= 1;
    master_refresh_n <= 1;
    master_hits_internal <= 0;
  endtask
  // request demultiplexing, encoded acknowledge and channel check
  task automatic tst_mux();
    dma_ack_valid <= 1;
    chan_check_n <= 0;
    repeat (8) @(negedge clk_sys);
    `CHK(irq_lines, irq_vec)
    `CHK(dma_req_lines, drq_vec)
    `CHK(encoded_dma_ack_out, 3'h5)
    `CHK(nmi, 1'b1)
    `CHK(rtc_irq_to_ctrl, ~irq_vec[8])
    sys_ctrl_port <= 8'hF7;
    dma_ack_valid <= 0;
    repeat (8) @(negedge clk_sys);
    `CHK(nmi, 1'b0)
    `CHK(encoded_dma_ack_out, 3'h7)
    chan_check_n <= 1;
    $display("test done mux");
  endtask
  initial
  begin
    repeat (5) @(negedge clk_sys);
    sys_rst <= 0;
    scen(ibx_pkg::IBX_IO, 1, 24'h71, 0, 0, 5'b10100, 8'h04);
    scen(ibx_pkg::IBX_IO, 0, 24'h71, 0, 1, 5'b10010, 8'h08);
    scen(ibx_pkg::IBX_IO, 1, 24'h70, 0, 0, 5'b10001, 8'h04);
    scen(ibx_pkg::IBX_IO, 0, 24'h60, 0, 0, 5'b01000, 8'h08);
    scen(ibx_pkg::IBX_IO, 1, 24'h64, 0, 1, 5'b01000, 8'h04);
    scen(ibx_pkg::IBX_IO, 0, 24'h80, 0, 0, 5'b00000, 8'h08);
    scen(ibx_pkg::IBX_MEM, 0, 24'h0E0000, 0, 0, 5'b10000, 8'hA0);
    scen(ibx_pkg::IBX_MEM, 1, 24'h0F0000, 0, 1, 5'b10000, 8'h50);
    scen(ibx_pkg::IBX_MEM, 1, 24'h100000, 1, 0, 5'b00000, 8'h42);
    scen(ibx_pkg::IBX_MEM, 0, 24'hFFFFFF, 1, 0, 5'b00000, 8'h82);
    scen(ibx_pkg::IBX_REFRESH, 0, 24'h0, 0, 0, 5'b00000, 8'hA1);
    scen(ibx_pkg::IBX_DMA, 0, 24'h1000, 0, 0, 5'b00000, 8'hA4);
    tst_master();
    tst_mux();
    stop_test();
  end
endmodule
`default_nettype wire
